/* File: include/pbs_pkg.sv */
// shared constants and types for the pipelined burst sram port
package pbs_pkg;
    localparam int ADDR_W = 15;
    localparam int DATA_W = 36;
    localparam int LANES = 4;
    localparam int LANE_W = 9;
    localparam int DEPTH = 32768;
    localparam int BURST_W = 2;
    localparam logic [1:0] BURST_LAST = 2'h3;
    localparam logic [1:0] BURST_FIRST = 2'h0;
    localparam logic [3:0] ALL_LANES = 4'hF;
    localparam logic [3:0] NO_LANES = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_RST = 15'h0000;
    localparam logic [DATA_W-1:0] DATA_RST = 36'h000000000;
    typedef enum logic [1:0] {
        PBS_IDLE = 2'b00,
        PBS_READ = 2'b01,
        PBS_WRITE = 2'b11
    } pbs_op_e;
endpackage

/* File: hdl/pbs_sram_port.sv */
// pipelined burst synchronous sram port: control front end and storage array
`timescale 1ns/1ps

module pbs_sram_port
    import pbs_pkg::*;
#(
    parameter int AW = ADDR_W,
    parameter int DW = DATA_W
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // address and strobes
    input wire logic [AW-1:0] addr,
    input wire logic processor_addr_strobe_n,
    input wire logic controller_addr_strobe_n,
    input wire logic burst_advance_n,
    // chip selects
    input wire logic chip_select_one_n,
    input wire logic chip_select_two,
    input wire logic chip_select_three_n,
    // write controls
    input wire logic global_write_n,
    input wire logic byte_write_enable_n,
    input wire logic [LANES-1:0] byte_lane_select_n,
    // asynchronous controls and static strap
    input wire logic output_enable_n,
    input wire logic sleep_request,
    input wire logic burst_order_interleaved,
    // data pins, split into three signals, and the sleep flag
    input wire logic [DW-1:0] data_in,
    output logic [DW-1:0] data_out,
    output logic [DW-1:0] data_oe,
    output logic sleep_active
);
    localparam int LW = DW / LANES;

    typedef struct packed {
        logic [AW-1:0] base;
        logic [1:0] step;
        logic selected;
        logic [LANES-1:0] wr_lanes;
        logic [AW-1:0] wr_addr;
        logic [DW-1:0] wr_data;
        logic rd_pend;
        logic rd_first;
        logic [AW-1:0] rd_addr;
        logic arr_pend;
        logic arr_first;
        logic [DW-1:0] out_reg;
        logic out_valid;
        logic was_desel;
        logic first_mask;
        logic sleep;
    } pbs_state_s;

    pbs_state_s st_reg;
    pbs_state_s st_next;
    logic [1:0] rst_sync_reg;
    logic rst_n;
    wire logic [DW-1:0] rd_word;

    // burst address low bits from loaded value and step count
    function automatic logic [1:0] burst_low(input logic [1:0] start, input logic [1:0] step,
                                             input logic interleaved);
        if (interleaved) begin
            burst_low = start ^ step;
        end else begin
            burst_low = 2'(start + step);
        end
    endfunction

    // full word address: upper bits held, low bits from the burst counter
    function automatic logic [AW-1:0] burst_addr(input logic [AW-1:0] base,
                                                 input logic [1:0] step,
                                                 input logic interleaved);
        burst_addr = {base[AW-1:BURST_W], burst_low(base[1:0], step, interleaved)};
    endfunction

    // counter moves only on advance inside a live burst
    function automatic logic [1:0] next_step(input logic [1:0] step,
                                             input logic adv_n,
                                             input logic live);
        if (!adv_n && live) begin
            next_step = 2'(step + 2'h1);
        end else begin
            next_step = step;
        end
    endfunction

    // three-pin select decode
    function automatic logic chip_selected(input logic cs_one_n,
                                           input logic cs_two,
                                           input logic cs_three_n);
        chip_selected = !cs_one_n && cs_two && !cs_three_n;
    endfunction

    // lanes a cycle would write; global write overrides the byte controls
    function automatic logic [LANES-1:0] lane_mask(input logic gw_n,
                                                   input logic bwe_n,
                                                   input logic [LANES-1:0] sel_n);
        if (!gw_n) begin
            lane_mask = ALL_LANES;
        end else if (!bwe_n) begin
            lane_mask = ~sel_n;
        end else begin
            lane_mask = NO_LANES;
        end
    endfunction

    // reset release through two flops
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rst_sync_reg <= 2'b00;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    logic psp_take;
    logic csp_take;
    logic load;
    logic sel_now;
    logic [LANES-1:0] lanes;
    logic access_live;
    logic is_write;
    logic rd_now;
    logic [AW-1:0] cur_addr;
    logic [1:0] step_adv;

    // processor strobe needs select one low and wins over the controller
    // strobe, so one address phase never loads twice
    assign psp_take = !processor_addr_strobe_n && !chip_select_one_n;
    assign csp_take = !controller_addr_strobe_n && !psp_take;
    assign load = psp_take || csp_take;
    assign sel_now = chip_selected(chip_select_one_n, chip_select_two, chip_select_three_n);
    assign lanes = lane_mask(global_write_n, byte_write_enable_n, byte_lane_select_n);

    always_comb begin
        st_next = st_reg;
        access_live = 1'b0;
        is_write = 1'b0;
        rd_now = 1'b0;
        step_adv = st_reg.step;
        cur_addr = st_reg.base;

        // address stage: chip selects are looked at only on a load
        if (load) begin
            st_next.base = addr;
            st_next.step = BURST_FIRST;
            st_next.selected = sel_now;
            step_adv = BURST_FIRST;
            cur_addr = addr;
            access_live = sel_now;
        end else begin
            step_adv = next_step(st_reg.step, burst_advance_n, st_reg.selected);
            st_next.step = step_adv;
            cur_addr = burst_addr(st_reg.base, step_adv, burst_order_interleaved);
            access_live = st_reg.selected;
        end

        // processor strobe cycles are always reads; write controls come next clock
        is_write = access_live && !psp_take && (lanes != NO_LANES);
        rd_now = access_live && !is_write;

        // write pipeline: capture address, data and lanes, commit next edge
        st_next.wr_lanes = is_write ? lanes : NO_LANES;
        st_next.wr_addr = cur_addr;
        st_next.wr_data = data_in;

        // read stage 0: address captured, first-after-deselect flag rides along
        st_next.rd_pend = rd_now;
        st_next.rd_first = load && st_reg.was_desel;
        st_next.rd_addr = cur_addr;

        // read stage 1: array word settles in the lane registers
        st_next.arr_pend = st_reg.rd_pend;
        st_next.arr_first = st_reg.rd_first;

        // read stage 2: output register
        st_next.out_valid = st_reg.arr_pend;
        st_next.first_mask = st_reg.arr_first;
        if (st_reg.arr_pend) begin
            st_next.out_reg = rd_word;
        end

        // deselected state lasts from a deselecting load to the next selected one
        st_next.was_desel = load ? !sel_now : (st_reg.was_desel && !st_reg.rd_pend);
        st_next.sleep = sleep_request;
    end

    // one array per lane, so a byte write never disturbs its neighbours;
    // a write commits one edge before any later read reaches the array
    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_lane
            logic [LW-1:0] lane_mem [DEPTH];
            logic [LW-1:0] lane_rd_reg;
            always_ff @(posedge ref_clk) begin
                if (st_reg.wr_lanes[g] && !st_reg.sleep) begin
                    lane_mem[st_reg.wr_addr] <= st_reg.wr_data[g*LW +: LW];
                end
                lane_rd_reg <= lane_mem[st_reg.rd_addr];
            end
            assign rd_word[g*LW +: LW] = lane_rd_reg;
        end
    endgenerate

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '{
                base: ADDR_RST,
                step: BURST_FIRST,
                selected: 1'b0,
                wr_lanes: NO_LANES,
                wr_addr: ADDR_RST,
                wr_data: DATA_RST,
                rd_pend: 1'b0,
                rd_first: 1'b0,
                rd_addr: ADDR_RST,
                arr_pend: 1'b0,
                arr_first: 1'b0,
                out_reg: DATA_RST,
                out_valid: 1'b0,
                // reset counts as deselected, so a word read on the first selected load is masked
                was_desel: 1'b1,
                first_mask: 1'b0,
                sleep: 1'b0
            };
        end else begin
            st_reg <= st_next;
        end
    end

    // oe gates the registered drive without sampling; the only non-flop path
    // out of the block is this gate, accepted so oe acts asynchronously
    always_comb begin
        data_out = st_reg.out_reg;
        data_oe = (!output_enable_n && st_reg.out_valid && !st_reg.first_mask && !sleep_request)
                  ? {DW{1'b1}} : {DW{1'b0}};
        sleep_active = st_reg.sleep;
    end
endmodule

/* File: dv/pbs_sram_port_asserts.sv */
// concurrent checks on the burst sram port pins
`timescale 1ns/1ps
module pbs_sram_port_asserts
    import pbs_pkg::*;
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic processor_addr_strobe_n,
    input wire logic controller_addr_strobe_n,
    input wire logic burst_advance_n,
    input wire logic chip_select_one_n,
    input wire logic chip_select_two,
    input wire logic chip_select_three_n,
    input wire logic global_write_n,
    input wire logic byte_write_enable_n,
    input wire logic output_enable_n,
    input wire logic sleep_request,
    input wire logic sleep_active,
    input wire logic [DATA_W-1:0] data_out,
    input wire logic [DATA_W-1:0] data_oe
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    sequence desel_load;
        !controller_addr_strobe_n && (chip_select_one_n || !chip_select_two || chip_select_three_n);
    endsequence
    sequence read_load;
        !controller_addr_strobe_n && !chip_select_one_n && chip_select_two && !chip_select_three_n
            && global_write_n && byte_write_enable_n && !sleep_request;
    endsequence
    sequence idle;
        controller_addr_strobe_n && (processor_addr_strobe_n || chip_select_one_n);
    endsequence
    // no load, no step, no write: the same word must come out twice
    sequence hold;
        controller_addr_strobe_n && (processor_addr_strobe_n || chip_select_one_n) && burst_advance_n
            && global_write_n && byte_write_enable_n && !sleep_request;
    endsequence
    a_oe_off: assert property (output_enable_n |-> data_oe == '0) else $error("pins driven with oe high");
    a_sleep_off: assert property (sleep_request |-> data_oe == '0) else $error("pins driven in sleep");
    a_oe_uniform: assert property (data_oe == '0 || data_oe == '1) else $error("split enable");
    a_first_mask: assert property (desel_load ##1 read_load |-> ##3 data_oe == '0) else $error("first word driven");
    a_desel_quiet: assert property (desel_load ##1 idle [*3] |-> data_oe == '0) else $error("deselected drive");
    a_hold_stable: assert property (hold ##1 hold |-> ##3 $stable(data_out)) else $error("held word changed");
    a_reset_quiet: assert property ($rose(resetn) |-> (data_oe == '0) [*4]) else $error("drive after reset");
    a_sleep_flag: assert property (sleep_request |=> sleep_active) else $error("sleep flag missing");
endmodule

bind pbs_sram_port pbs_sram_port_asserts pbs_sram_port_asserts_inst (.*);

/* File: dv/pbs_host_bus.sv */
// far-side data pins: host write data wherever the port releases the bus
`timescale 1ns/1ps
module pbs_host_bus
    import pbs_pkg::*;
(
    input wire logic [DATA_W-1:0] data_out,
    input wire logic [DATA_W-1:0] data_oe,
    input wire logic [DATA_W-1:0] host_data,
    output logic [DATA_W-1:0] data_in
);
    // host value changes every cycle, so a stale word never passes for a fresh one
    assign data_in = (data_out & data_oe) | (host_data & ~data_oe);
endmodule

/* File: dv/pbs_sram_port_tb_top.sv */
// self-checking bench: random bus traffic against a behavioural port model
`timescale 1ns/1ps
module pbs_sram_port_tb_top;
    import pbs_pkg::*;
    logic ref_clk = 0, resetn = 0, processor_addr_strobe_n = 1, controller_addr_strobe_n = 1;
    logic burst_advance_n = 1, chip_select_one_n = 0, chip_select_two = 1, chip_select_three_n = 0;
    logic global_write_n = 1, byte_write_enable_n = 1, output_enable_n = 1, sleep_request = 0;
    logic burst_order_interleaved = 0, sleep_active;
    logic [LANES-1:0] byte_lane_select_n = 4'hF;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] host_data = '0, r = 36'h000000028, data_in, data_out, data_oe;
    logic [DATA_W-1:0] mem [int];
    logic [DATA_W+1:0] pipe [3] = '{default: '0};
    int err_count = 0, cmp_count = 0, cyc_count = 0, base = 0, step = 0, sel = 0, desel = 1;
    pbs_sram_port pbs_sram_port_inst (.*);
    pbs_host_bus pbs_host_bus_inst (.*);
    always #5 ref_clk = ~ref_clk;
    function automatic logic [DATA_W-1:0] lfsr(logic [DATA_W-1:0] v);
        return {v[34:0], v[35] ^ v[24]};
    endfunction
    task automatic chk(logic [DATA_W-1:0] seen, logic [DATA_W-1:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run;
        if (err_count == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // i >= 0 fills the word at {i[6:5], 8'h00, i[4:0]} with a global write; otherwise a random cycle
    task automatic step_bus(int i);
        logic w;
        #1;
        r = lfsr(r);
        w = i >= 0 || r[14] && r[15];
        controller_addr_strobe_n = i < 0 && (r[0] || r[1]);
        processor_addr_strobe_n = i >= 0 || r[2] || r[3];
        chip_select_one_n = i < 0 && r[4] && r[5] && r[6];
        chip_select_two = i >= 0 || !(r[7] && r[8]);
        chip_select_three_n = i < 0 && r[9] && r[10] && r[11];
        burst_advance_n = r[12];
        global_write_n = !(w && (i >= 0 || r[13]));
        byte_write_enable_n = !(w && !r[13]);
        byte_lane_select_n = &r[19:16] ? 4'hE : r[19:16];
        output_enable_n = w || r[20] && r[21];
        sleep_request = !w && &r[25:22];
        addr = i >= 0 ? {i[6:5], 8'h00, i[4:0]} : {r[27:26], 8'h00, r[32:28]};
        host_data = {r[17:0], r[35:18]};
        @(posedge ref_clk);
    endtask
    always @(posedge ref_clk) begin
        logic ld, rd, fst;
        logic [DATA_W-1:0] m;
        int a;
        if (!resetn) begin
            sel = 0;
            desel = 1;
            pipe = '{default: '0};
        end
        ld = !controller_addr_strobe_n || !processor_addr_strobe_n && !chip_select_one_n;
        rd = !processor_addr_strobe_n && !chip_select_one_n || global_write_n && byte_write_enable_n;
        fst = ld && desel;
        if (ld) begin
            base = addr;
            step = 0;
            sel = !chip_select_one_n && chip_select_two && !chip_select_three_n;
            desel = !sel;
        end else begin
            step += !burst_advance_n;
        end
        a = {base[14:2], burst_order_interleaved ? base[1:0] ^ step[1:0] : base[1:0] + step[1:0]};
        m = mem.exists(a) ? mem[a] : '0;
        if (sel && !rd && !sleep_request) begin
            for (int k = 0; k < LANES; k++) begin
                if (!global_write_n || !byte_lane_select_n[k]) begin
                    m[k*LANE_W+:LANE_W] = data_in[k*LANE_W+:LANE_W];
                end
            end
            mem[a] = m;
        end
        pipe[2] = pipe[1];
        pipe[1] = pipe[0];
        pipe[0] = {sel != 0 && rd && !sleep_request, fst, m};
        cyc_count++;
        if (cyc_count > 6000) begin
            err_count++;
            complete_run();
        end
        #2;
        if (resetn && pipe[2][DATA_W+1]) begin
            chk(data_oe, pipe[2][DATA_W] || output_enable_n || sleep_request ? '0 : '1);
            if (!pipe[2][DATA_W]) chk(data_out, pipe[2][DATA_W-1:0]);
        end
    end
    initial begin
        for (int p = 0; p < 2; p++) begin
            #1;
            resetn = 0;
            controller_addr_strobe_n = 1;
            processor_addr_strobe_n = 1;
            sleep_request = 0;
            burst_order_interleaved = p[0];
            repeat (3) @(posedge ref_clk);
            #1;
            resetn = 1;
            repeat (4) @(posedge ref_clk);
            for (int i = 0; i < 128; i++) step_bus(i);
            for (int i = 0; i < 2000; i++) step_bus(-1);
        end
        complete_run();
    end
endmodule
